// File: hdl/eepse_pkg.sv
package eepse_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the APB bus)
  // ----------------------------------------------------------------
  localparam logic [12:0] OFS_MODULE_CONFIG = 13'h0000;
  localparam logic [12:0] OFS_BLOCK_PROTECT = 13'h0004;
  localparam logic [12:0] OFS_CONTROL = 13'h0008;
  localparam logic [12:0] OFS_DIV_HIGH = 13'h000c;
  localparam logic [12:0] OFS_DIV_LOW = 13'h0010;
  localparam logic [12:0] OFS_STATUS = 13'h0014;
  localparam logic [12:0] OFS_DIV_LOW_ALIAS = 13'h0018;
  localparam int ARRAY_SEL_BIT = 12;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int ARRAY_BYTES = 1024;
  localparam logic [9:0] SHADOW_HI_IDX = 10'h3c0;
  localparam logic [9:0] SHADOW_LO_IDX = 10'h3c1;
  localparam logic [9:0] BLK4_END = 10'h1ff;
  localparam logic [9:0] BLK3_END = 10'h2ff;
  localparam logic [9:0] BLK2_END = 10'h37f;
  localparam logic [9:0] BLK1_END = 10'h3bf;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [15:0] SHADOW_ERASED = 16'hffff;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MCR_DBG_LOCKOUT_DIS = 7;
  localparam int MCR_SHADOW_DIS = 6;
  localparam int MCR_TEST = 5;
  localparam int MCR_FLASH_OPEN = 4;
  localparam int MCR_PROT_LOCK = 1;
  localparam int MCR_DUMMY = 0;
  localparam int BPR_SHADOW_PROTECT = 7;
  localparam int BPR_BULK_PROTECT = 5;
  localparam int CTL_AUTO = 6;
  localparam int CTL_BYTE = 5;
  localparam int CTL_ROW = 4;
  localparam int CTL_ERASE = 2;
  localparam int CTL_LATCH = 1;
  localparam int CTL_HV = 0;
  localparam logic [7:0] MCR_FIXED_ONES = 8'h0c;
  localparam logic [7:0] BPR_RESET = 8'hbf;

  // ----------------------------------------------------------------
  // Timing: divider ticks last 35 us, pulse lasts 10 ms
  // ----------------------------------------------------------------
  localparam int PULSE_TIME_US = 10000;
  localparam int TICK_TIME_NS = 35000;
  localparam int PULSE_TICKS_DEF = (PULSE_TIME_US * 1000 + TICK_TIME_NS - 1) / TICK_TIME_NS;

  // Control bits travel together
  typedef struct packed {
    logic auto_clr;
    logic byte_sel;
    logic row_sel;
    logic erase;
    logic bulk_protect;
    logic latch_enable;
    logic high_voltage_enable;
  } eepse_ctl_t;

endpackage

// File: hdl/eepse_pulse_timer.sv
`timescale 1ns/1ps
module eepse_pulse_timer
  import eepse_pkg::*;
#(
  parameter int PULSE_TICKS = PULSE_TICKS_DEF
)
(
  input wire logic clk_i, // Device clock, also the oscillator
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic run_i, // Level, high while a cycle runs
  input wire logic [9:0] div_i, // Combined divider value
  output logic done_o // One-cycle pulse at pulse end
);

  logic [9:0] presc;
  logic [15:0] ticks;
  logic [9:0] next_presc;
  logic [15:0] next_ticks;
  logic next_done;

  // Prescale the oscillator by the divider, then count ticks
  always_comb
  begin
    next_presc = presc;
    next_ticks = ticks;
    next_done = 1'b0;
    if (!run_i)
    begin
      next_presc = 10'h000;
      next_ticks = 16'h0000;
    end
    else if (presc >= div_i - 10'h001)
    begin
      next_presc = 10'h000;
      if (ticks >= 16'(PULSE_TICKS - 1))
      begin
        next_done = 1'b1;
        next_ticks = 16'h0000;
      end
      else
      begin
        next_ticks = ticks + 16'h0001;
      end
    end
    else
    begin
      next_presc = presc + 10'h001;
    end
  end

  // Timer registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      presc <= 10'h000;
      ticks <= 16'h0000;
      done_o <= 1'b0;
    end
    else
    begin
      presc <= next_presc;
      ticks <= next_ticks;
      done_o <= next_done;
    end
  end

endmodule // eepse_pulse_timer

// File: hdl/eepse_top.sv
`timescale 1ns/1ps
module eepse_top
  import eepse_pkg::*;
#(
  parameter int PULSE_TICKS = PULSE_TICKS_DEF
)
(
  input wire logic clk_i, // 20 MHz device clock
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic special_mode_n_i, // Pin, low selects special mode
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [12:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data, registered
  output logic pready, // APB ready
  output logic pslverr // APB error, registered
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] mem [ARRAY_BYTES] = '{default: ERASED_BYTE}; // Array is delivered erased
  logic [15:0] shadow = SHADOW_ERASED; // Nonvolatile, survives reset
  logic [7:0] module_config_reg;
  logic [7:0] block_protect_reg;
  eepse_ctl_t ctl;
  logic [1:0] clock_divider_high;
  logic [7:0] clock_divider_low;
  logic div_locked;
  logic tgt_valid;
  logic tgt_word;
  logic [9:0] tgt_idx;
  logic [15:0] tgt_data;
  logic cyc_done;
  logic [7:0] next_mcr;
  logic [7:0] next_bpr;
  eepse_ctl_t next_ctl;
  logic [1:0] next_div_hi;
  logic [7:0] next_div_lo;
  logic next_div_locked;
  logic next_tgt_valid;
  logic next_tgt_word;
  logic [9:0] next_tgt_idx;
  logic [15:0] next_tgt_data;
  logic next_cyc_done;
  logic smod_meta;
  logic smod_sync;
  logic [9:0] clock_divider_value;
  logic wr_acc;
  logic rd_setup;
  logic arr_sel;
  logic [9:0] idx;
  logic shadow_on;
  logic tgt_protected;
  logic run;
  logic done;
  logic [7:0] arr_rd;
  logic [31:0] next_prdata;
  logic next_pslverr;

  // ----------------------------------------------------------------
  // Mode pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    smod_meta <= special_mode_n_i;
    smod_sync <= smod_meta;
  end

  // Bus decode; APB writes take effect on the access edge
  assign pready = penable;
  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign arr_sel = paddr[ARRAY_SEL_BIT];
  assign idx = paddr[11:2];
  assign clock_divider_value = {clock_divider_high, clock_divider_low};
  assign shadow_on = !module_config_reg[MCR_SHADOW_DIS];

  // Protection check for the latched target
  always_comb
  begin
    tgt_protected = 1'b0;
    if (ctl.erase && !ctl.byte_sel)
    begin
      tgt_protected = block_protect_reg[BPR_BULK_PROTECT] || (|block_protect_reg[4:0]);
    end
    else if (shadow_on && (tgt_idx == SHADOW_HI_IDX || tgt_idx == SHADOW_LO_IDX))
    begin
      tgt_protected = block_protect_reg[BPR_SHADOW_PROTECT];
    end
    else if (tgt_idx <= BLK4_END)
    begin
      tgt_protected = block_protect_reg[4];
    end
    else if (tgt_idx <= BLK3_END)
    begin
      tgt_protected = block_protect_reg[3];
    end
    else if (tgt_idx <= BLK2_END)
    begin
      tgt_protected = block_protect_reg[2];
    end
    else if (tgt_idx <= BLK1_END)
    begin
      tgt_protected = block_protect_reg[1];
    end
    else
    begin
      tgt_protected = block_protect_reg[0];
    end
  end

  // A cycle runs only with voltage on, a target, a divider, no protection
  assign run = ctl.high_voltage_enable && tgt_valid && !cyc_done && !tgt_protected
    && (clock_divider_value != 10'h000);

  eepse_pulse_timer #(
    .PULSE_TICKS(PULSE_TICKS)
  ) u_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .run_i(run),
    .div_i(clock_divider_value),
    .done_o(done)
  );

  // ----------------------------------------------------------------
  // Register and sequencing next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_mcr = module_config_reg;
    next_bpr = block_protect_reg;
    next_ctl = ctl;
    next_div_hi = clock_divider_high;
    next_div_lo = clock_divider_low;
    next_div_locked = div_locked;
    next_tgt_valid = tgt_valid;
    next_tgt_word = tgt_word;
    next_tgt_idx = tgt_idx;
    next_tgt_data = tgt_data;
    next_cyc_done = cyc_done;
    if (done)
    begin
      next_cyc_done = 1'b1;
      if (ctl.auto_clr)
      begin
        next_ctl.high_voltage_enable = 1'b0;
      end
    end
    if (wr_acc && !arr_sel && pstrb[0])
    begin
      case (paddr)
        OFS_MODULE_CONFIG:
        begin
          if (!smod_sync)
          begin
            next_mcr[7:4] = pwdata[7:4];
            next_mcr[MCR_PROT_LOCK] = pwdata[MCR_PROT_LOCK];
          end
          else if (!module_config_reg[MCR_PROT_LOCK])
          begin
            next_mcr[MCR_PROT_LOCK] = pwdata[MCR_PROT_LOCK]; // Write once set
          end
          next_mcr[MCR_DUMMY] = pwdata[MCR_DUMMY];
        end
        OFS_BLOCK_PROTECT:
        begin
          if (!ctl.high_voltage_enable && !module_config_reg[MCR_PROT_LOCK])
          begin
            next_bpr = pwdata[7:0];
          end
        end
        OFS_CONTROL:
        begin
          if (!ctl.high_voltage_enable)
          begin
            next_ctl.auto_clr = pwdata[CTL_AUTO];
            next_ctl.byte_sel = pwdata[CTL_BYTE];
            next_ctl.row_sel = pwdata[CTL_ROW];
            next_ctl.erase = pwdata[CTL_ERASE];
            next_ctl.bulk_protect = pwdata[7];
            if (clock_divider_value != 10'h000)
            begin
              next_ctl.latch_enable = pwdata[CTL_LATCH];
            end
            // Voltage needs the latch already set before this write
            next_ctl.high_voltage_enable = pwdata[CTL_HV] && ctl.latch_enable
              && pwdata[CTL_LATCH];
            next_cyc_done = done; // A cycle ending now stays marked
          end
          else
          begin
            next_ctl.high_voltage_enable = pwdata[CTL_HV];
          end
          if (!next_ctl.latch_enable)
          begin
            next_tgt_valid = 1'b0;
          end
        end
        OFS_DIV_HIGH, OFS_DIV_LOW, OFS_DIV_LOW_ALIAS:
        begin
          if (!smod_sync || !div_locked)
          begin
            if (paddr == OFS_DIV_HIGH)
            begin
              next_div_hi = pwdata[1:0];
            end
            else
            begin
              next_div_lo = pwdata[7:0];
            end
            next_div_locked = smod_sync;
          end
        end
        default:
        begin
          next_div_locked = div_locked;
        end
      endcase
    end
    // Latch target while latching is on and voltage is off
    if (wr_acc && arr_sel && ctl.latch_enable && !ctl.high_voltage_enable)
    begin
      next_tgt_valid = 1'b1;
      next_tgt_idx = idx;
      next_tgt_word = pstrb[1] && !idx[0];
      next_tgt_data = pwdata[15:0];
      next_cyc_done = done;
    end
  end

  // Control registers; reset reloads configuration from shadow word
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      module_config_reg <= {shadow[15:12], MCR_FIXED_ONES[3:0]};
      clock_divider_high <= shadow[9:8];
      clock_divider_low <= shadow[7:0];
      block_protect_reg <= BPR_RESET;
      ctl <= '0;
      div_locked <= 1'b0;
      tgt_valid <= 1'b0;
      tgt_word <= 1'b0;
      tgt_idx <= 10'h000;
      tgt_data <= 16'h0000;
      cyc_done <= 1'b0;
    end
    else
    begin
      module_config_reg <= {next_mcr[7:4], MCR_FIXED_ONES[3:2], next_mcr[1:0]};
      clock_divider_high <= next_div_hi;
      clock_divider_low <= next_div_lo;
      block_protect_reg <= next_bpr;
      ctl <= next_ctl;
      div_locked <= next_div_locked;
      tgt_valid <= next_tgt_valid;
      tgt_word <= next_tgt_word;
      tgt_idx <= next_tgt_idx;
      tgt_data <= next_tgt_data;
      cyc_done <= next_cyc_done;
    end
  end

  // ----------------------------------------------------------------
  // Array and shadow update at cycle end; program clears bits only
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (done)
    begin
      for (int i = 0; i < ARRAY_BYTES; i++)
      begin
        if (ctl.erase && !ctl.byte_sel && (!ctl.row_sel || i[9:5] == tgt_idx[9:5]))
        begin
          mem[i] <= ERASED_BYTE;
        end
        // Shadow overlay hides the regular bytes, so only bulk or row erase changes them
        else if (!(shadow_on && i[9:1] == SHADOW_HI_IDX[9:1])
          && (i[9:0] == tgt_idx || (tgt_word && i[9:0] == (tgt_idx | 10'h001))))
        begin
          mem[i] <= ctl.erase ? ERASED_BYTE
            : mem[i] & ((i[9:0] == tgt_idx) ? tgt_data[7:0] : tgt_data[15:8]);
        end
      end
      if (shadow_on && tgt_idx[9:1] == SHADOW_HI_IDX[9:1] && ctl.erase)
      begin
        shadow <= SHADOW_ERASED;
      end
      else if (shadow_on && tgt_idx == SHADOW_HI_IDX)
      begin
        shadow[15:8] <= shadow[15:8] & tgt_data[7:0];
        shadow[7:0] <= tgt_word ? (shadow[7:0] & tgt_data[15:8]) : shadow[7:0];
      end
      else if (shadow_on && tgt_idx == SHADOW_LO_IDX)
      begin
        shadow[7:0] <= shadow[7:0] & tgt_data[7:0];
      end
    end
  end

  // Array read with shadow overlay
  always_comb
  begin
    arr_rd = mem[idx];
    if (shadow_on && idx == SHADOW_HI_IDX)
    begin
      arr_rd = shadow[15:8];
    end
    else if (shadow_on && idx == SHADOW_LO_IDX)
    begin
      arr_rd = shadow[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Read data, captured in setup so it stands during access
  // ----------------------------------------------------------------
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (arr_sel)
    begin
      next_prdata[7:0] = arr_rd;
    end
    else
    begin
      case (paddr)
        OFS_MODULE_CONFIG: next_prdata[7:0] = module_config_reg;
        OFS_BLOCK_PROTECT: next_prdata[7:0] = block_protect_reg;
        OFS_CONTROL: next_prdata[7:0] = {ctl.bulk_protect, ctl.auto_clr, ctl.byte_sel,
          ctl.row_sel, 1'b0, ctl.erase, ctl.latch_enable, ctl.high_voltage_enable};
        OFS_DIV_HIGH: next_prdata[1:0] = clock_divider_high;
        OFS_DIV_LOW, OFS_DIV_LOW_ALIAS: next_prdata[7:0] = clock_divider_low;
        OFS_STATUS: next_prdata[3:0] = {!smod_sync, div_locked, tgt_valid, run};
        default: next_pslverr = 1'b1;
      endcase
    end
  end

  // Bus answer registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (rd_setup)
    begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= next_pslverr;
    end
  end

endmodule // eepse_top

// File: verification/eepse_checker.sv
`timescale 1ns/1ps
module eepse_checker
  import eepse_pkg::*;
#(
  parameter int PULSE_TICKS = PULSE_TICKS_DEF
)
(
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Reset, active low
  input wire logic special_mode_n_i, // Mode pin
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [12:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB strobes
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr // APB error
);
  // --------
  // Write-once tracking
  // --------
  logic acc;
  logic rd_acc;
  logic div_wr;
  logic [1:0] mode_q;
  logic [1:0] next_mode_q;
  logic locked;
  logic next_locked;
  logic has_lo;
  logic next_has_lo;
  logic [7:0] lo_val;
  logic [7:0] next_lo_val;

  // Mode pin gets the same two-stage lag as inside the block
  assign acc = psel && penable;
  assign rd_acc = acc && !pwrite;
  assign div_wr = acc && pwrite && pstrb[0] && mode_q[1]
    && (paddr == OFS_DIV_LOW || paddr == OFS_DIV_HIGH);

  // First normal-mode divider write locks both bytes
  always_comb
  begin
    next_mode_q = {mode_q[0], special_mode_n_i};
    next_locked = rst_n_i && (locked || div_wr);
    next_has_lo = rst_n_i && has_lo;
    next_lo_val = lo_val;
    if (div_wr && !locked && paddr == OFS_DIV_LOW)
    begin
      next_has_lo = rst_n_i;
      next_lo_val = pwdata[7:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    mode_q <= next_mode_q;
    locked <= next_locked;
    has_lo <= next_has_lo;
    lo_val <= next_lo_val;
  end

  // --------
  // Properties
  // --------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_ready_access:
    assert property (acc |-> pready)
    else $error("ready missing in access phase");
  chk_ready_idle:
    assert property (!penable |-> !pready)
    else $error("ready outside access phase");
  chk_array_no_err:
    assert property (acc && paddr[12] |-> !pslverr)
    else $error("error on array access");
  chk_unmapped_err:
    assert property (acc && !paddr[12] && paddr[11:0] > 12'h018 |-> pslverr)
    else $error("no error on unmapped offset");
  chk_reset_quiet:
    assert property ($rose(rst_n_i) |-> prdata == 32'h0 && !pslverr)
    else $error("outputs not cleared by reset");
  chk_cfg_fixed_ones:
    assert property (rd_acc && paddr == OFS_MODULE_CONFIG |-> prdata[3:2] == 2'b11)
    else $error("config fixed bits not one");
  chk_hv_with_latch:
    assert property (rd_acc && paddr == OFS_CONTROL && prdata[CTL_HV] |-> prdata[CTL_LATCH])
    else $error("high voltage set without latch");
  chk_div_write_once:
    assert property (rd_acc && paddr == OFS_DIV_LOW && has_lo && mode_q[1]
      |-> prdata[7:0] == lo_val)
    else $error("divider changed after first write");
endmodule // eepse_checker

bind eepse_top eepse_checker #(.PULSE_TICKS(PULSE_TICKS)) eepse_checker_i (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .special_mode_n_i(special_mode_n_i),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr)
);

// File: verification/tb_eepse_top.sv
`timescale 1ns/1ps
module tb_eepse_top;
  import eepse_pkg::*;

  // --------
  // Signals
  // --------
  localparam int TICKS = 3; // Short pulse keeps each cycle a few clocks
  typedef struct packed {
    logic [32:0] msk;
    logic [32:0] val;
  } eepse_note_t;

  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic special_mode_n_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [12:0] paddr = 13'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rdv;
  logic [31:0] lfsr = 32'h7e507b20;
  eepse_note_t notes[$];
  eepse_note_t note;
  int err_count = 0;
  int comparisons = 0;

  eepse_top #(.PULSE_TICKS(TICKS)) eepse_top_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .special_mode_n_i(special_mode_n_i),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr)
  );

  // 20 MHz clock
  initial
  begin
    forever #25 clk_i = ~clk_i;
  end

  // --------
  // Tasks
  // --------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [12:0] arr(input int i);
    return 13'h1000 + 13'(4 * i);
  endfunction

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Request is held until ready is sampled high, then released
  task automatic bus(input logic w, input logic [12:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk_i);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1)
      @(posedge clk_i);
    rdv = prdata;
    {psel, penable} <= 2'b00;
  endtask

  task automatic wr(input logic [12:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask

  // A zero mask marks a poll whose value is not compared
  task automatic rd(input logic [12:0] a, input logic [32:0] e,
                    input logic [32:0] m = 33'h1000000ff);
    notes.push_back('{m, e & m});
    bus(1'b0, a, 32'h0, 4'h0);
  endtask

  // Latch a target, raise high voltage, try to disturb it, poll
  task automatic prog(input int i, input logic [31:0] d, input logic [3:0] s,
                      input logic [31:0] ctl, input logic stay);
    int n;
    wr(OFS_CONTROL, ctl);
    bus(1'b1, arr(i), d, s);
    wr(OFS_CONTROL, ctl | 32'h1);
    bus(1'b1, arr(i), 32'h0, 4'h1);
    rd(OFS_CONTROL, ctl | 32'h1);
    n = 0;
    rdv = 32'h1;
    // A protected target never ends its cycle, so it only gets time to fail
    while (!stay && rdv[CTL_HV] !== 1'b0 && n < 30)
    begin
      rd(OFS_CONTROL, 33'h0, 33'h0);
      n++;
    end
    if (stay)
      repeat (30) @(posedge clk_i);
    check(33'(n == 30), 33'h0);
    rd(OFS_CONTROL, stay ? (ctl | 32'h1) : ctl);
  endtask

  task automatic close_out();
    if (err_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Oldest note is compared when read data appears
  always @(posedge clk_i)
  begin
    if ((psel && penable && pready && !pwrite) === 1'b1 && notes.size() > 0)
    begin
      note = notes.pop_front();
      if (note.msk != 33'h0)
        check({pslverr, prdata} & note.msk, note.val);
    end
  end

  // --------
  // Sequence
  // --------
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(OFS_MODULE_CONFIG, 33'hfc);
    rd(OFS_BLOCK_PROTECT, 33'hbf);
    rd(OFS_CONTROL, 33'h0);
    rd(OFS_DIV_HIGH, 33'h3);
    rd(OFS_DIV_LOW, 33'hff);
    rd(13'h001c, 33'h100000000, 33'h100000000);
    // Normal mode keeps only the first divider write
    wr(OFS_DIV_LOW, 32'h2);
    wr(OFS_DIV_LOW, 32'h5);
    wr(OFS_DIV_HIGH, 32'h0);
    rd(OFS_DIV_LOW, 33'h2);
    rd(OFS_DIV_HIGH, 33'h3);
    rd(OFS_STATUS, 33'h4);
    // Special mode reopens the divider; zero blocks the latch
    special_mode_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    wr(OFS_DIV_HIGH, 32'h0);
    wr(OFS_DIV_LOW, 32'h0);
    wr(OFS_CONTROL, 32'h2);
    rd(OFS_CONTROL, 33'h0);
    wr(OFS_DIV_LOW, 32'h2);
    rd(OFS_DIV_HIGH, 33'h0);
    rd(OFS_DIV_LOW, 33'h2);
    wr(OFS_BLOCK_PROTECT, 32'h0);
    wr(OFS_CONTROL, 32'h43);
    rd(OFS_CONTROL, 33'h42);
    lfsr = lfsr_next(lfsr);
    prog(5, lfsr, 4'h1, 32'h42, 1'b0);
    prog(8, 32'h1234, 4'h3, 32'h42, 1'b0);
    wr(OFS_CONTROL, 32'h0);
    rd(arr(5), {25'h0, lfsr[7:0]});
    rd(arr(8), 33'h34);
    rd(arr(9), 33'h12);
    // Byte-mode erase of an aligned word
    prog(8, 32'h0, 4'h3, 32'h66, 1'b0);
    wr(OFS_CONTROL, 32'h0);
    rd(arr(8), 33'hff);
    rd(arr(9), 33'hff);
    // Row erase clears the whole first row
    prog(5, 32'h0, 4'h1, 32'h56, 1'b0);
    wr(OFS_CONTROL, 32'h0);
    rd(arr(5), 33'hff);
    // Protected target never completes
    wr(OFS_BLOCK_PROTECT, 32'h10);
    prog(16, 32'h0, 4'h1, 32'h42, 1'b1);
    wr(OFS_CONTROL, 32'h42);
    wr(OFS_CONTROL, 32'h0);
    rd(arr(16), 33'hff);
    // Shadow word holds the divider and reloads it on reset
    wr(OFS_BLOCK_PROTECT, 32'h0);
    wr(OFS_MODULE_CONFIG, 32'hbc);
    rd(OFS_MODULE_CONFIG, 33'hbc);
    prog(960, 32'h02fc, 4'h3, 32'h42, 1'b0);
    wr(OFS_CONTROL, 32'h0);
    rd(arr(960), 33'hfc);
    rd(arr(961), 33'h02);
    wr(OFS_BLOCK_PROTECT, 32'h80);
    rd(OFS_BLOCK_PROTECT, 33'h80);
    wr(OFS_MODULE_CONFIG, 32'hfc);
    rd(arr(961), 33'hff);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(OFS_DIV_HIGH, 33'h0);
    rd(OFS_DIV_LOW, 33'h2);
    rd(OFS_DIV_LOW_ALIAS, 33'h2);
    rd(OFS_STATUS, 33'h8);
    rd(OFS_MODULE_CONFIG, 33'hfc);
    @(posedge clk_i);
    close_out();
  end

  // Watchdog far beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    close_out();
  end
endmodule // tb_eepse_top
